/* File: rtl/apsp_consts.vh */
// Constants shared by the ASCII parameter protocol interpreter and its reply sender.
`ifndef APSP_CONSTS_VH
`define APSP_CONSTS_VH

// Protocol control characters.
`define APSP_C_STX 8'h02
`define APSP_C_ETX 8'h03
`define APSP_C_EOT 8'h04
`define APSP_C_ENQ 8'h05
`define APSP_C_ACK 8'h06
`define APSP_C_BS 8'h08
`define APSP_C_NAK 8'h15

// Printable characters used in data fields.
`define APSP_C_ZERO 8'h30
`define APSP_C_PLUS 8'h2B
`define APSP_C_MINUS 8'h2D

// Checksum floor: results below it are lifted by the same amount.
`define APSP_BCC_MIN 8'h20

// Field lengths and last positions in characters.
`define APSP_ADDR_HALF 3'h2
`define APSP_ADDR_LAST 3'h3
`define APSP_PAR_LAST 3'h3
`define APSP_DATA_HIRES 3'h6

// Reply kinds handed to the sender.
`define APSP_KIND_ACK 2'h0
`define APSP_KIND_NAK 2'h1
`define APSP_KIND_EOT 2'h2
`define APSP_KIND_FRAME 2'h3

// Reply frame character positions.
`define APSP_IDX_SIGN 4'h5
`define APSP_IDX_ETX 4'hA
`define APSP_IDX_LAST 4'hB

`endif

/* File: rtl/apsp_reply_tx.v */
// Reply sender: emits single answer characters or a full data reply frame.
`timescale 1ns/1ps
`include "apsp_consts.vh"

module apsp_reply_tx (
  // Clock and reset.
  input wire clk_in,
  input wire arst_n_in,
  // Reply request.
  input wire start_in,
  input wire [1:0] kind_in,
  input wire [15:0] num_in,
  input wire sign_in,
  input wire [19:0] mag_in,
  input wire wide_in,
  // Character stream towards the line transmitter.
  input wire tx_ready_in,
  output reg tx_valid_out,
  output reg [7:0] tx_data_out,
  output reg busy_out
);

  // Lifts a checksum out of the control-character range.
  function [7:0] bcc_fix;
    input [7:0] x;
    begin
      bcc_fix = (x < `APSP_BCC_MIN) ? x + `APSP_BCC_MIN : x;
    end
  endfunction

  // Turns one BCD digit into its ASCII character.
  function [7:0] dig_char;
    input [3:0] d;
    begin
      dig_char = `APSP_C_ZERO | {4'h0, d};
    end
  endfunction

  reg [1:0] kind_reg; // Latched reply kind.
  reg [15:0] num_reg; // Latched parameter number, four BCD digits.
  reg sign_reg; // Latched sign, high for negative.
  reg [19:0] mag_reg; // Latched magnitude, five BCD digits.
  reg wide_reg; // Latched wide-integer flag.
  reg [3:0] idx_reg; // Position of the character in flight.
  reg [7:0] bcc_reg; // Running XOR after the start character.
  reg [7:0] char_next; // Character for the current position.
  wire last_w; // High on the final character of the reply.

  assign last_w = (kind_reg != `APSP_KIND_FRAME) || (idx_reg == `APSP_IDX_LAST);

  // Picks the character for the current position.
  always @* begin
    char_next = bcc_fix(bcc_reg);
    if (kind_reg == `APSP_KIND_ACK) begin
      char_next = `APSP_C_ACK;
    end else if (kind_reg == `APSP_KIND_NAK) begin
      char_next = `APSP_C_NAK;
    end else if (kind_reg == `APSP_KIND_EOT) begin
      char_next = `APSP_C_EOT;
    end else begin
      case (idx_reg)
        4'h0: char_next = `APSP_C_STX;
        4'h1: char_next = dig_char(num_reg[15:12]);
        4'h2: char_next = dig_char(num_reg[11:8]);
        4'h3: char_next = dig_char(num_reg[7:4]);
        4'h4: char_next = dig_char(num_reg[3:0]);
        // Wide integers carry five digits and no sign.
        `APSP_IDX_SIGN: char_next = wide_reg ? dig_char(mag_reg[19:16]) :
                                   (sign_reg ? `APSP_C_MINUS : `APSP_C_PLUS);
        4'h6: char_next = dig_char(mag_reg[15:12]);
        4'h7: char_next = dig_char(mag_reg[11:8]);
        4'h8: char_next = dig_char(mag_reg[7:4]);
        4'h9: char_next = dig_char(mag_reg[3:0]);
        `APSP_IDX_ETX: char_next = `APSP_C_ETX;
        default: char_next = bcc_fix(bcc_reg);
      endcase
    end
  end

  // Loads one character, waits for the line to take it, then steps on.
  // A gap cycle between characters keeps the data path registered.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      kind_reg <= `APSP_KIND_ACK;
      num_reg <= 16'h0000;
      sign_reg <= 1'b0;
      mag_reg <= 20'h00000;
      wide_reg <= 1'b0;
      idx_reg <= 4'h0;
      bcc_reg <= 8'h00;
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
      busy_out <= 1'b0;
    end else if (!busy_out) begin
      // Idle: capture a new request.
      if (start_in) begin
        kind_reg <= kind_in;
        num_reg <= num_in;
        sign_reg <= sign_in;
        mag_reg <= mag_in;
        wide_reg <= wide_in;
        idx_reg <= 4'h0;
        bcc_reg <= 8'h00;
        busy_out <= 1'b1;
      end
    end else if (!tx_valid_out) begin
      // Present the next character.
      tx_data_out <= char_next;
      tx_valid_out <= 1'b1;
    end else if (tx_ready_in) begin
      // Character taken; the start character stays out of the checksum.
      tx_valid_out <= 1'b0;
      if (idx_reg != 4'h0) begin
        bcc_reg <= bcc_reg ^ tx_data_out;
      end
      if (last_w) begin
        busy_out <= 1'b0;
      end else begin
        idx_reg <= idx_reg + 4'h1;
      end
    end
  end

endmodule

/* File: rtl/apsp_interp.v */
// Parameter protocol interpreter: parses host frames and drives storage and replies.
// Function
// - Write frame: reset, address, STX, number, data, ETX, checksum.
// - Accepted write answered with one ACK.
// - Malformed, too long or bad checksum gets NAK.
// - Out-of-limit write value rejected with NAK.
// - Six data characters mean high-resolution write.
// - Wide integers use five digits, no sign.
// - Read reply: STX, number, five data, ETX, checksum.
// - Reply data starts with sign, then magnitude.
// - NAK after reply repeats same parameter.
// - ACK after reply reads next parameter.
// - Backspace after reply reads previous parameter.
// - Unknown parameter answered with EOT.
// - Checksum XORs characters after STX through ETX.
// - Checksum below 32 gets 32 added.
// - Address 00 is broadcast; never answered.
// - Address digits each sent twice after reset.
// - Control characters use their fixed ASCII codes.
// - Parameter number is four decimal digits.
`timescale 1ns/1ps
`include "apsp_consts.vh"

module apsp_interp (
  // Clock and reset.
  input wire clk_in,
  input wire arst_n_in,
  // Received characters from the line receiver, same clock.
  input wire rx_valid_in,
  input wire [7:0] rx_data_in,
  // Transmitted characters towards the line transmitter.
  input wire tx_ready_in,
  output wire tx_valid_out,
  output wire [7:0] tx_data_out,
  // Own serial address, two BCD digits.
  input wire [7:0] addr_in,
  // Parameter storage request.
  output wire par_req_out,
  output wire par_write_out,
  output wire [15:0] par_num_out,
  output wire par_wneg_out,
  output wire [23:0] par_wdigits_out,
  output wire [2:0] par_wlen_out,
  output wire par_hires_out,
  // Parameter storage answer.
  input wire par_done_in,
  input wire par_exists_in,
  input wire par_ok_in,
  input wire par_rneg_in,
  input wire [19:0] par_rmag_in,
  input wire par_rwide_in
);

  //////////////////////////////////////////////////////////////////////////////
  // Parser states.
  localparam S_IDLE = 4'h0;
  localparam S_ADDR = 4'h1;
  localparam S_SEL = 4'h2;
  localparam S_RPAR = 4'h3;
  localparam S_RENQ = 4'h4;
  localparam S_WPAR = 4'h5;
  localparam S_WDAT = 4'h6;
  localparam S_WBCC = 4'h7;
  localparam S_STORE = 4'h8;
  localparam S_TX = 4'h9;
  localparam S_FAIL = 4'hA;
  localparam S_SKIP = 4'hB;

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // High when a character is an ASCII decimal digit.
  function is_digit;
    input [7:0] c;
    begin
      is_digit = (c >= `APSP_C_ZERO) && (c <= (`APSP_C_ZERO | 8'h09));
    end
  endfunction

  // Lifts a checksum out of the control-character range.
  function [7:0] bcc_fix;
    input [7:0] x;
    begin
      bcc_fix = (x < `APSP_BCC_MIN) ? x + `APSP_BCC_MIN : x;
    end
  endfunction

  // Steps a four-digit BCD number up or down by one, wrapping at the ends.
  function [15:0] bcd_step;
    input [15:0] n;
    input up;
    integer i;
    reg carry;
    reg [3:0] d;
    begin
      carry = 1'b1;
      bcd_step = n;
      for (i = 0; i < 4; i = i + 1) begin
        d = n[i*4 +: 4];
        if (carry) begin
          if (up) begin
            carry = (d == 4'h9);
            d = carry ? 4'h0 : d + 4'h1;
          end else begin
            carry = (d == 4'h0);
            d = carry ? 4'h9 : d - 4'h1;
          end
        end
        bcd_step[i*4 +: 4] = d;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State and datapath registers.
  reg [3:0] state_reg; // Parser state.
  reg [2:0] cnt_reg; // Characters taken in the current field.
  reg match_reg; // Address digits so far equal our own.
  reg bcast_reg; // Address digits so far all zero.
  reg cont_reg; // A data reply went out; stepping characters are live.
  reg [7:0] bcc_reg; // Running XOR of the received command.
  reg req_reg; // One-cycle storage request.
  reg write_reg; // Request is a write.
  reg [15:0] num_reg; // Parameter number, four BCD digits.
  reg wneg_reg; // Write value is negative.
  reg sign_seen_reg; // A sign opened the data field.
  reg [23:0] wdig_reg; // Write digits, right aligned BCD.
  reg [2:0] wlen_reg; // Data characters of the last write.
  reg hires_reg; // Last write asked for high resolution.
  reg tx_start_reg; // One-cycle reply request.
  reg [1:0] tx_kind_reg; // Reply kind.
  reg rneg_reg; // Captured read sign.
  reg [19:0] rmag_reg; // Captured read magnitude.
  reg rwide_reg; // Captured wide-integer flag.
  wire tx_busy_w; // Sender still working.
  wire [3:0] dig_w; // Received digit value.
  wire [3:0] exp_w; // Address digit expected at this position.
  wire parsing_w; // Parser is inside or between frames.
  wire dig_ok_w; // Received character is a digit.

  assign dig_w = rx_data_in[3:0];
  assign dig_ok_w = is_digit(rx_data_in);
  // Each digit arrives twice: tens, tens, units, units.
  assign exp_w = (cnt_reg < `APSP_ADDR_HALF) ? addr_in[7:4] : addr_in[3:0];
  // While storage or the sender work, the parser does not listen.
  assign parsing_w = (state_reg != S_STORE) && (state_reg != S_TX) && (state_reg != S_FAIL);

  assign par_req_out = req_reg;
  assign par_write_out = write_reg;
  assign par_num_out = num_reg;
  assign par_wneg_out = wneg_reg;
  assign par_wdigits_out = wdig_reg;
  assign par_wlen_out = wlen_reg;
  assign par_hires_out = hires_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Main parser. Characters are consumed one per rx_valid_in pulse.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= S_IDLE;
      cnt_reg <= 3'h0;
      match_reg <= 1'b0;
      bcast_reg <= 1'b0;
      cont_reg <= 1'b0;
      bcc_reg <= 8'h00;
      req_reg <= 1'b0;
      write_reg <= 1'b0;
      num_reg <= 16'h0000;
      wneg_reg <= 1'b0;
      sign_seen_reg <= 1'b0;
      wdig_reg <= 24'h000000;
      wlen_reg <= 3'h0;
      hires_reg <= 1'b0;
      tx_start_reg <= 1'b0;
      tx_kind_reg <= `APSP_KIND_ACK;
      rneg_reg <= 1'b0;
      rmag_reg <= 20'h00000;
      rwide_reg <= 1'b0;
    end else begin
      req_reg <= 1'b0;
      tx_start_reg <= 1'b0;
      if (parsing_w && rx_valid_in && (rx_data_in == `APSP_C_EOT)) begin
        // Reset character: drop whatever was half received.
        state_reg <= S_ADDR;
        cnt_reg <= 3'h0;
        match_reg <= 1'b1;
        bcast_reg <= 1'b1;
        cont_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            // Between frames only stepping characters after a reply matter.
            if (rx_valid_in && cont_reg) begin
              if (rx_data_in == `APSP_C_NAK) begin
                write_reg <= 1'b0;
                req_reg <= 1'b1;
                state_reg <= S_STORE;
              end else if (rx_data_in == `APSP_C_ACK) begin
                num_reg <= bcd_step(num_reg, 1'b1);
                write_reg <= 1'b0;
                req_reg <= 1'b1;
                state_reg <= S_STORE;
              end else if (rx_data_in == `APSP_C_BS) begin
                num_reg <= bcd_step(num_reg, 1'b0);
                write_reg <= 1'b0;
                req_reg <= 1'b1;
                state_reg <= S_STORE;
              end
            end
          end
          S_ADDR: begin
            if (rx_valid_in) begin
              if (!dig_ok_w) begin
                // Unreadable address: nobody can be sure it was meant for us.
                state_reg <= S_SKIP;
              end else begin
                match_reg <= match_reg && (dig_w == exp_w);
                bcast_reg <= bcast_reg && (dig_w == 4'h0);
                cnt_reg <= cnt_reg + 3'h1;
                if (cnt_reg == `APSP_ADDR_LAST) begin
                  if ((match_reg && (dig_w == exp_w)) || (bcast_reg && (dig_w == 4'h0))) begin
                    state_reg <= S_SEL;
                  end else begin
                    state_reg <= S_SKIP;
                  end
                end
              end
            end
          end
          S_SEL: begin
            // STX opens a command; a digit opens a read request.
            if (rx_valid_in) begin
              cnt_reg <= 3'h1;
              if (rx_data_in == `APSP_C_STX) begin
                cnt_reg <= 3'h0;
                bcc_reg <= 8'h00;
                state_reg <= S_WPAR;
              end else if (dig_ok_w) begin
                num_reg <= {num_reg[11:0], dig_w};
                state_reg <= S_RPAR;
              end else begin
                state_reg <= S_FAIL;
              end
            end
          end
          S_RPAR: begin
            if (rx_valid_in) begin
              if (dig_ok_w) begin
                num_reg <= {num_reg[11:0], dig_w};
                cnt_reg <= cnt_reg + 3'h1;
                if (cnt_reg == `APSP_PAR_LAST) begin
                  state_reg <= S_RENQ;
                end
              end else begin
                state_reg <= S_FAIL;
              end
            end
          end
          S_RENQ: begin
            // Reads carry no checksum; ENQ ends them.
            if (rx_valid_in) begin
              if (rx_data_in != `APSP_C_ENQ) begin
                state_reg <= S_FAIL;
              end else if (bcast_reg) begin
                state_reg <= S_IDLE;
              end else begin
                write_reg <= 1'b0;
                req_reg <= 1'b1;
                state_reg <= S_STORE;
              end
            end
          end
          S_WPAR: begin
            if (rx_valid_in) begin
              bcc_reg <= bcc_reg ^ rx_data_in;
              if (dig_ok_w) begin
                num_reg <= {num_reg[11:0], dig_w};
                cnt_reg <= cnt_reg + 3'h1;
                if (cnt_reg == `APSP_PAR_LAST) begin
                  cnt_reg <= 3'h0;
                  sign_seen_reg <= 1'b0;
                  wneg_reg <= 1'b0;
                  wdig_reg <= 24'h000000;
                  state_reg <= S_WDAT;
                end
              end else begin
                state_reg <= S_FAIL;
              end
            end
          end
          S_WDAT: begin
            if (rx_valid_in) begin
              bcc_reg <= bcc_reg ^ rx_data_in;
              if (rx_data_in == `APSP_C_ETX) begin
                // An empty field or a lone sign carries no value.
                if ((cnt_reg == 3'h0) || ((cnt_reg == 3'h1) && sign_seen_reg)) begin
                  state_reg <= S_FAIL;
                end else begin
                  wlen_reg <= cnt_reg;
                  hires_reg <= (cnt_reg == `APSP_DATA_HIRES);
                  state_reg <= S_WBCC;
                end
              end else if (cnt_reg == `APSP_DATA_HIRES) begin
                state_reg <= S_FAIL;
              end else if ((cnt_reg == 3'h0) &&
                           ((rx_data_in == `APSP_C_PLUS) || (rx_data_in == `APSP_C_MINUS))) begin
                // A sign is optional; without one the field may hold a wide integer.
                sign_seen_reg <= 1'b1;
                wneg_reg <= (rx_data_in == `APSP_C_MINUS);
                cnt_reg <= cnt_reg + 3'h1;
              end else if (dig_ok_w) begin
                wdig_reg <= {wdig_reg[19:0], dig_w};
                cnt_reg <= cnt_reg + 3'h1;
              end else begin
                state_reg <= S_FAIL;
              end
            end
          end
          S_WBCC: begin
            // Broadcast commands are applied too, just never answered.
            if (rx_valid_in) begin
              if (rx_data_in == bcc_fix(bcc_reg)) begin
                write_reg <= 1'b1;
                req_reg <= 1'b1;
                state_reg <= S_STORE;
              end else begin
                state_reg <= S_FAIL;
              end
            end
          end
          S_STORE: begin
            // Wait for storage; its answer picks the reply.
            if (par_done_in) begin
              if (write_reg) begin
                if (bcast_reg) begin
                  state_reg <= S_IDLE;
                end else begin
                  if (!par_exists_in) begin
                    tx_kind_reg <= `APSP_KIND_EOT;
                  end else if (!par_ok_in) begin
                    tx_kind_reg <= `APSP_KIND_NAK;
                  end else begin
                    tx_kind_reg <= `APSP_KIND_ACK;
                  end
                  tx_start_reg <= 1'b1;
                  state_reg <= S_TX;
                end
              end else begin
                rneg_reg <= par_rneg_in;
                rmag_reg <= par_rmag_in;
                rwide_reg <= par_rwide_in;
                tx_kind_reg <= par_exists_in ? `APSP_KIND_FRAME : `APSP_KIND_EOT;
                cont_reg <= par_exists_in;
                tx_start_reg <= 1'b1;
                state_reg <= S_TX;
              end
            end
          end
          S_TX: begin
            // The start pulse masks the one cycle before the sender turns busy.
            if (!tx_start_reg && !tx_busy_w) begin
              state_reg <= S_IDLE;
            end
          end
          S_FAIL: begin
            if (bcast_reg) begin
              state_reg <= S_IDLE;
            end else begin
              tx_kind_reg <= `APSP_KIND_NAK;
              tx_start_reg <= 1'b1;
              state_reg <= S_TX;
            end
          end
          S_SKIP: begin
            // Frame for another station: only a reset character leaves here.
            state_reg <= S_SKIP;
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reply sender.
  apsp_reply_tx u_tx (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .start_in(tx_start_reg),
    .kind_in(tx_kind_reg),
    .num_in(num_reg),
    .sign_in(rneg_reg),
    .mag_in(rmag_reg),
    .wide_in(rwide_reg),
    .tx_ready_in(tx_ready_in),
    .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out),
    .busy_out(tx_busy_w)
  );

endmodule

/* File: test/apsp_interp_chk.sv */
// Port checker for the parameter protocol interpreter.
`timescale 1ns/1ps
module apsp_interp_chk (
  // Clock and reset.
  input wire clk_in,
  input wire arst_n_in,
  // Character streams.
  input wire rx_valid_in,
  input wire tx_ready_in,
  input wire tx_valid_out,
  input wire [7:0] tx_data_out,
  // Storage request.
  input wire par_req_out,
  input wire par_write_out,
  input wire [2:0] par_wlen_out,
  input wire par_hires_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // A character offered but not yet taken, and one taken.
  sequence s_held; tx_valid_out && !tx_ready_in; endsequence
  sequence s_taken; tx_valid_out && tx_ready_in; endsequence
  a_tx_hold: assert property (s_held |=> tx_valid_out && $stable(tx_data_out))
    else $error("tx character changed before it was taken");
  a_tx_gap: assert property (s_taken |=> !tx_valid_out)
    else $error("no idle cycle after a taken character");
  a_char_legal: assert property (tx_valid_out |-> (tx_data_out >= 8'h20 ||
    tx_data_out inside {8'h02, 8'h03, 8'h04, 8'h06, 8'h15})) else $error("illegal tx character");
  a_req_pulse: assert property (par_req_out |=> !par_req_out)
    else $error("storage request longer than one cycle");
  a_req_cause: assert property (par_req_out |-> $past(rx_valid_in))
    else $error("storage request without a final character");
  a_req_quiet: assert property (par_req_out |-> !tx_valid_out)
    else $error("reply sent while storage is asked");
  a_hires_six: assert property (par_req_out && par_write_out |-> par_hires_out == (par_wlen_out == 3'h6))
    else $error("high resolution flag wrong");
  a_wlen_range: assert property (par_req_out && par_write_out |-> par_wlen_out inside {[1:6]})
    else $error("data field length out of range");
endmodule
bind apsp_interp apsp_interp_chk apsp_interp_chk_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .rx_valid_in(rx_valid_in), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
  .tx_data_out(tx_data_out), .par_req_out(par_req_out), .par_write_out(par_write_out),
  .par_wlen_out(par_wlen_out), .par_hires_out(par_hires_out));

/* File: test/apsp_store_model.sv */
// Behavioural parameter store answering the interpreter's requests.
`timescale 1ns/1ps
module apsp_store_model (
  // Clock and reset.
  input wire clk_in,
  input wire arst_n_in,
  // Request.
  input wire req_in,
  input wire [15:0] num_in,
  input wire [23:0] wdigits_in,
  // Answer.
  output reg done_out,
  output reg exists_out,
  output reg ok_out,
  output reg rneg_out,
  output reg [19:0] rmag_out,
  output reg rwide_out
);
  reg [1:0] wait_reg; // Answer delay, so the parser must really wait.
  ////////////////////////////////////////////////////////////
  // Fields follow the held number and write digits; only done is timed.
  always @* begin
    exists_out = (num_in != 16'h1723);
    ok_out = (wdigits_in <= 24'h050000);
    rneg_out = num_in[0];
    rmag_out = {4'h9, num_in};
    rwide_out = (num_in == 16'h1314);
  end
  // Done comes four cycles after the request.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_reg <= 2'h0;
      done_out <= 1'b0;
    end else begin
      wait_reg <= req_in ? 2'h3 : (wait_reg == 2'h0 ? 2'h0 : wait_reg - 2'h1);
      done_out <= (wait_reg == 2'h1);
    end
  end
endmodule

/* File: test/tb_apsp_interp.sv */
// Self-checking testbench for the parameter protocol interpreter.
`timescale 1ns/1ps
module tb_apsp_interp;
  reg clk_in, arst_n_in, rx_valid_in, tx_ready_in;
  reg [7:0] rx_data_in, addr_in, x_reg;
  reg [23:0] lfsr_reg;
  wire tx_valid_out, req, wr, wneg, hires, done, ex, ok, rneg, rwide;
  wire [7:0] tx_data_out;
  wire [15:0] num;
  wire [23:0] wdig;
  wire [2:0] wlen;
  wire [19:0] rmag;
  integer err_count, n_tests, i;
  reg [7:0] exp_q[$]; // Expected tx characters, oldest first.
  reg [25:0] pexp_reg; // Next storage request: {minus, write, last two digits, number}.
  apsp_interp apsp_interp_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .rx_valid_in(rx_valid_in),
    .rx_data_in(rx_data_in), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .addr_in(addr_in), .par_req_out(req), .par_write_out(wr),
    .par_num_out(num), .par_wneg_out(wneg), .par_wdigits_out(wdig), .par_wlen_out(wlen),
    .par_hires_out(hires), .par_done_in(done), .par_exists_in(ex), .par_ok_in(ok),
    .par_rneg_in(rneg), .par_rmag_in(rmag), .par_rwide_in(rwide));
  apsp_store_model apsp_store_model_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req),
    .num_in(num), .wdigits_in(wdig), .done_out(done), .exists_out(ex), .ok_out(ok),
    .rneg_out(rneg), .rmag_out(rmag), .rwide_out(rwide));
  ////////////////////////////////////////////////////////////
  task chk(input string what, input [23:0] seen, input [23:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One received character, one cycle long, folded into the XOR.
  task send(input [7:0] c);
    @(negedge clk_in);
    rx_valid_in = 1'b1;
    rx_data_in = c;
    x_reg = x_reg ^ c;
    @(negedge clk_in);
    rx_valid_in = 1'b0;
  endtask
  task head(input [7:0] a); // Reset char then each address digit twice.
    send(8'h04);
    send(8'h30 | a[7:4]);
    send(8'h30 | a[7:4]);
    send(8'h30 | a[3:0]);
    send(8'h30 | a[3:0]);
  endtask
  task send_num(input [15:0] n);
    for (i = 0; i < 4; i++) send(8'h30 | n[15-4*i -: 4]);
  endtask
  task wait_idle; // Bounded wait for all replies, then some quiet time.
    for (i = 0; i < 3000 && exp_q.size() != 0; i++) @(negedge clk_in);
    chk("reply_wait", 8'(exp_q.size()), 8'h00);
    repeat (16) @(negedge clk_in);
  endtask
  // Expected reply frame; 1314 is wide, the rest signed.
  task exp_frame(input [15:0] n);
    reg [7:0] x, c;
    x = 8'h00;
    exp_q.push_back(8'h02);
    for (i = 0; i < 10; i++) begin
      c = (i == 9) ? 8'h03 : (i == 4) ? ((n == 16'h1314) ? 8'h39 : n[0] ? 8'h2D : 8'h2B) :
        8'h30 | n[15-4*(i%5) -: 4];
      exp_q.push_back(c);
      x = x ^ c;
    end
    exp_q.push_back(x < 8'h20 ? x + 8'h20 : x);
  endtask
  task read_req(input [7:0] a, input [15:0] n);
    pexp_reg = {10'h000, n};
    head(a);
    send_num(n);
    send(8'h05);
    wait_idle;
  endtask
  task write_cmd(input [7:0] a, input [15:0] n, input string s, input [7:0] flip, input [7:0] reply);
    if (reply != 8'h00) exp_q.push_back(reply);
    pexp_reg = {s[0] == "-", 1'b1, (8'(s[s.len()-2] << 4) | (s[s.len()-1] & 8'h0F)), n};
    head(a);
    send(8'h02);
    x_reg = 8'h00;
    send_num(n);
    for (i = 0; i < s.len(); i++) send(s[i]);
    send(8'h03);
    send((x_reg < 8'h20 ? x_reg + 8'h20 : x_reg) ^ flip);
    wait_idle;
  endtask
  task step(input [7:0] c, input [15:0] n);
    pexp_reg = {10'h000, n};
    exp_frame(n);
    send(c);
    wait_idle;
  endtask
  // Each taken tx character against the oldest note.
  always @(posedge clk_in) if (arst_n_in && tx_valid_out === 1'b1 && tx_ready_in)
    chk("tx_char", tx_data_out, exp_q.size() ? exp_q.pop_front() : 8'hXX);
  always @(posedge clk_in) if (arst_n_in && req === 1'b1) begin
    chk("par_num", num, pexp_reg[15:0]);
    chk("par_write", wr, pexp_reg[24]);
    if (wr) chk("par_wdata", {wneg, wdig[7:0]}, {pexp_reg[25], pexp_reg[23:16]});
  end
  function [23:0] lfsr_next(input [23:0] s);
    lfsr_next = {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction
  always @(negedge clk_in) begin // Random stalls from the line transmitter.
    lfsr_reg <= lfsr_next(lfsr_reg);
    tx_ready_in <= lfsr_reg[0] | lfsr_reg[1];
  end
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    #400000;
    err_count = err_count + 1;
    tally_and_finish;
  end
  initial begin
    {arst_n_in, rx_valid_in, tx_ready_in, rx_data_in, x_reg} = 0;
    addr_in = 8'h12; // No zero digit in the own address.
    lfsr_reg = 24'h014201;
    err_count = 0;
    n_tests = 0;
    repeat (4) @(negedge clk_in);
    arst_n_in = 1'b1;
    exp_frame(16'h0117);
    read_req(8'h12, 16'h0117);
    step(8'h06, 16'h0118);
    step(8'h08, 16'h0117);
    step(8'h15, 16'h0117);
    exp_frame(16'h0999);
    read_req(8'h12, 16'h0999);
    step(8'h06, 16'h1000);
    step(8'h08, 16'h0999);
    exp_frame(16'h1314);
    read_req(8'h12, 16'h1314);
    exp_q.push_back(8'h04);
    read_req(8'h12, 16'h1723);
    send(8'h06);
    wait_idle;
    write_cmd(8'h12, 16'h0117, "-0476", 8'h00, 8'h06);
    write_cmd(8'h12, 16'h0117, "+04765", 8'h00, 8'h06);
    write_cmd(8'h12, 16'h0117, "99999", 8'h00, 8'h15);
    write_cmd(8'h12, 16'h0117, "-0476", 8'h01, 8'h15);
    write_cmd(8'h12, 16'h0117, "1234567", 8'h00, 8'h15);
    write_cmd(8'h12, 16'h1723, "1", 8'h00, 8'h04);
    write_cmd(8'h00, 16'h0117, "+00100", 8'h00, 8'h00);
    read_req(8'h13, 16'h0117);
    head(8'h12);
    send(8'h30);
    exp_frame(16'h0120);
    read_req(8'h12, 16'h0120);
    repeat (4) begin
      pexp_reg = {10'h000, 4'(lfsr_reg[3:0] % 10), 4'(lfsr_reg[7:4] % 10), 4'(lfsr_reg[11:8] % 10),
        4'(lfsr_reg[15:12] % 10)};
      exp_frame(pexp_reg[15:0]);
      read_req(8'h12, pexp_reg[15:0]);
    end
    tally_and_finish;
  end
endmodule
